// ==== core/rcc_clock_pwm.sv ====
// Converter operating clock generator: PWM timer with Avalon-MM registers
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

// Function
// - Counter runs on the clock and clears on cycle match; cycle sets period.
// - Compare-pair: pin starts high and goes high on every cycle match.
// - Compare-pair: pin goes low when the counter matches the duty compare.
// - Output clock period is 250 ns, a 4 MHz square wave, with cycle value 9; the reset cycle value 29 gives 30 cycles, 750 ns.
// - Compare-pair: cycle compare initialises to 29, duty compare to 14.
// - Saw-wave: counter counts up from 0 and wraps after cycle value 29.
// - Saw-wave: pin low at first compare 14, high at end of cycle.
// - Saw-wave: pin driven high when counting starts, low when stopped.
// - Saw-wave: no negation control; nothing external forces the pin inactive.
// - Unused second to sixth compares hold 28 to avoid out-of-range error.
// - Cycle and compare writes act directly, with no buffered reload.
module rcc_clock_pwm #(
  parameter rcc_pkg::variant_t VARIANT = rcc_pkg::VAR_PAIR,
  parameter int unsigned       CNT_W   = rcc_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // Avalon-MM slave
  input  wire logic [rcc_pkg::ADDR_W-1:0]    avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [rcc_pkg::DATA_W-1:0]    avs_writedata_i,
  input  wire logic [rcc_pkg::BE_W-1:0]      avs_byteenable_i,
  output logic      [rcc_pkg::DATA_W-1:0]    avs_readdata_o,
  output logic                               avs_waitrequest_o,
  // Converter clock pin
  output logic                               clock_out_pin_o
);

  localparam int unsigned SN = rcc_pkg::SPARE_N;
  localparam int unsigned DW = rcc_pkg::DATA_W;
  localparam logic PIN_RST = (VARIANT == rcc_pkg::VAR_SAW) ? rcc_pkg::PIN_LOW : rcc_pkg::PIN_HIGH;

  if (CNT_W < 5 || CNT_W > rcc_pkg::DATA_W) begin : g_bad_width
    $error("counter width cannot hold the documented compare values");
  end

  // Bus side
  rcc_pkg::bus_req_t  req;
  logic [DW-1:0]      rd_val;
  logic               wr_stb;

  // Registers
  logic               run_q;
  logic [CNT_W-1:0]   cycle_compare_reg_q;
  logic [CNT_W-1:0]   duty_compare_reg_q;
  logic [CNT_W-1:0]   spare_cmp_q [SN];
  logic               range_err_q;
  logic               pin_q;
  logic               pin_d;
  rcc_pkg::run_state_t state_q;
  rcc_pkg::run_state_t state_d;

  // Decode
  logic               hit_ctrl;
  logic               hit_status;
  logic               hit_cycle;
  logic               hit_duty;
  logic               hit_count;
  logic [SN-1:0]      hit_spare;
  logic [SN-1:0]      spare_over;
  logic [DW-1:0]      spare_rd [SN+1];
  logic               range_hit;

  // Timer
  logic [CNT_W-1:0]   period_counter;
  logic               wrap;
  logic               counting;
  logic               start;
  logic               stop;
  logic               duty_hit;

  function automatic logic [CNT_W-1:0] merge_lanes(input logic [CNT_W-1:0]           old_v,
                                                   input logic [DW-1:0]              wd,
                                                   input logic [rcc_pkg::BE_W-1:0]   be);
    logic [CNT_W-1:0] r;
    r = old_v;
    for (int k = 0; k < CNT_W; k++) begin
      if (be[k/8]) begin
        r[k] = wd[k];
      end
    end
    return r;
  endfunction

  assign req.rd    = avs_read_i;
  assign req.wr    = avs_write_i;
  assign req.addr  = avs_address_i;
  assign req.wdata = avs_writedata_i;
  assign req.be    = avs_byteenable_i;

  rcc_avalon_slave u_slave (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .req_i         (req),
    .rdval_i       (rd_val),
    .waitrequest_o (avs_waitrequest_o),
    .readdata_o    (avs_readdata_o),
    .wr_stb_o      (wr_stb)
  );

  assign hit_ctrl   = req.addr == rcc_pkg::OFF_CTRL;
  assign hit_status = req.addr == rcc_pkg::OFF_STATUS;
  assign hit_cycle  = req.addr == rcc_pkg::OFF_CYCLE;
  assign hit_duty   = req.addr == rcc_pkg::OFF_DUTY;
  assign hit_count  = req.addr == rcc_pkg::OFF_COUNT;

  // Second to sixth compares: decode, readback and range check per entry
  assign spare_rd[0] = '0;
  for (genvar i = 0; i < SN; i++) begin : g_spare
    localparam logic [rcc_pkg::ADDR_W-1:0] OFF_I =
      rcc_pkg::ADDR_W'(rcc_pkg::OFF_SPARE + i * rcc_pkg::OFF_STEP);
    assign hit_spare[i]  = req.addr == OFF_I;
    assign spare_over[i] = spare_cmp_q[i] > cycle_compare_reg_q;
    assign spare_rd[i+1] = spare_rd[i] | ({DW{hit_spare[i]}} & DW'(spare_cmp_q[i]));

    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        spare_cmp_q[i] <= CNT_W'(rcc_pkg::SPARE_RST);
      end else if (wr_stb && hit_spare[i]) begin
        spare_cmp_q[i] <= merge_lanes(spare_cmp_q[i], req.wdata, req.be);
      end
    end
  end

  // Any compare beyond the cycle would never match
  assign range_hit = (|spare_over) | (duty_compare_reg_q > cycle_compare_reg_q);

  // Unmapped addresses read as zero
  assign rd_val = ({DW{hit_ctrl}}   & DW'(run_q))
                | ({DW{hit_status}} & DW'({range_err_q, pin_q, counting}))
                | ({DW{hit_cycle}}  & DW'(cycle_compare_reg_q))
                | ({DW{hit_duty}}   & DW'(duty_compare_reg_q))
                | ({DW{hit_count}}  & DW'(period_counter))
                | spare_rd[SN];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_q               <= 1'b0;
      cycle_compare_reg_q <= CNT_W'(rcc_pkg::CYCLE_RST);
      duty_compare_reg_q  <= CNT_W'(rcc_pkg::DUTY_RST);
    end else begin
      if (wr_stb && hit_ctrl && req.be[0]) begin
        run_q <= req.wdata[rcc_pkg::CTRL_RUN];
      end
      if (wr_stb && hit_cycle) begin
        cycle_compare_reg_q <= merge_lanes(cycle_compare_reg_q, req.wdata, req.be);
      end
      if (wr_stb && hit_duty) begin
        duty_compare_reg_q <= merge_lanes(duty_compare_reg_q, req.wdata, req.be);
      end
    end
  end

  // Sticky range error, write one to clear; a new hit wins over the clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      range_err_q <= 1'b0;
    end else if (range_hit) begin
      range_err_q <= 1'b1;
    end else if (wr_stb && hit_status && req.be[0] && req.wdata[rcc_pkg::ST_RANGE]) begin
      range_err_q <= 1'b0;
    end
  end

  // Run control
  always_comb begin
    case (state_q)
      rcc_pkg::RUN_IDLE:  state_d = run_q ? rcc_pkg::RUN_COUNT : rcc_pkg::RUN_IDLE;
      rcc_pkg::RUN_COUNT: state_d = run_q ? rcc_pkg::RUN_COUNT : rcc_pkg::RUN_IDLE;
      default:            state_d = rcc_pkg::RUN_IDLE;
    endcase
  end

  assign counting = state_q == rcc_pkg::RUN_COUNT;
  assign start    = (state_q == rcc_pkg::RUN_IDLE) && run_q;
  assign stop     = counting && !run_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= rcc_pkg::RUN_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  rcc_period_counter #(
    .W (CNT_W)
  ) u_counter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (counting),
    .cycle_i (cycle_compare_reg_q),
    .count_o (period_counter),
    .wrap_o  (wrap)
  );

  // Duty register doubles as the saw-wave first compare; cycle match wins a tie
  assign duty_hit = counting && (period_counter == duty_compare_reg_q);

  // Pin logic has no negation input, so only the timer and, in the saw-wave variant, its start and stop move it
  if (VARIANT == rcc_pkg::VAR_SAW) begin : g_saw
    assign pin_d = start    ? rcc_pkg::PIN_HIGH :
                   stop     ? rcc_pkg::PIN_LOW :
                   wrap     ? rcc_pkg::PIN_HIGH :
                   duty_hit ? rcc_pkg::PIN_LOW :
                   pin_q;
  end else begin : g_pair
    assign pin_d = wrap     ? rcc_pkg::PIN_HIGH :
                   duty_hit ? rcc_pkg::PIN_LOW :
                   pin_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_q <= PIN_RST;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign clock_out_pin_o = pin_q;

  // Checking helpers: cycles between rising pin edges, with clean config
  logic [7:0] gap_q;
  logic       clean_q;
  logic       pin_rise;

  // Rise about to happen, so the gap is read before it restarts
  assign pin_rise = pin_d && !pin_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gap_q   <= 8'h00;
      clean_q <= 1'b0;
    end else begin
      gap_q <= (pin_d && !pin_q) ? 8'h01 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
      if (pin_d && !pin_q) begin
        clean_q <= counting || start;
      end else if (wr_stb || !counting) begin
        clean_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  localparam int unsigned OPC = rcc_pkg::OUT_PERIOD_CYC;

  sequence wrap_s;
    counting && period_counter >= cycle_compare_reg_q;
  endsequence

  sequence restart_s;
    period_counter == CNT_W'(rcc_pkg::COUNT_START) ##1 period_counter == CNT_W'(1);
  endsequence

  count_clear_a: assert property (
    wrap_s ##0 (run_q && !wr_stb) |=> restart_s)
    else $error("period counter did not restart after cycle match");

  count_step_a: assert property (
    counting && !wrap |=> period_counter == $past(period_counter) + 1'b1)
    else $error("period counter did not step by one");

  out_period_a: assert property (
    pin_rise && clean_q && cycle_compare_reg_q == CNT_W'(OPC - 1) |-> gap_q == 8'(OPC))
    else $error("output clock period differs from the nominal period");

  reset_vals_a: assert property (
    !$past(rst_n_i) |-> cycle_compare_reg_q == CNT_W'(rcc_pkg::CYCLE_RST)
                        && duty_compare_reg_q == CNT_W'(rcc_pkg::DUTY_RST)
                        && pin_q == PIN_RST)
    else $error("wrong values after reset");

  spare_init_a: assert property (
    !$past(rst_n_i) |-> spare_cmp_q[0] == CNT_W'(rcc_pkg::SPARE_RST) && !range_err_q)
    else $error("spare compare not at its reset value");

  range_flag_a: assert property (
    range_hit |=> range_err_q [*2])
    else $error("range error flag not raised or not held");

  direct_write_a: assert property (
    wr_stb && hit_cycle && req.be == 4'hF |=> cycle_compare_reg_q == CNT_W'($past(req.wdata)))
    else $error("cycle write did not take effect at once");

  if (VARIANT == rcc_pkg::VAR_SAW) begin : g_saw_chk
    saw_start_a: assert property (
      start |=> pin_q && counting && period_counter == CNT_W'(rcc_pkg::COUNT_START))
      else $error("pin not high at counting start");

    saw_stop_a: assert property (
      stop ##1 !run_q |=> !pin_q)
      else $error("pin not low after counting stopped");

    saw_edges_a: assert property (
      (duty_hit && !wrap && run_q |=> !pin_q) and (wrap && run_q |=> pin_q))
      else $error("saw-wave pin edge missing");
  end else begin : g_pair_chk
    pair_rise_a: assert property (
      wrap |=> pin_q)
      else $error("pin not high after cycle match");

    pair_fall_a: assert property (
      duty_hit && !wrap |=> !pin_q ##1 (pin_q || !wrap || $past(duty_hit)))
      else $error("pin not low after duty match");
  end

endmodule

// ==== include/rcc_pkg.sv ====
// Constants and types shared by the converter clock generator
package rcc_pkg;

  // Widths
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned ADDR_W  = 6;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned BE_W    = 4;
  localparam int unsigned SPARE_N = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CYCLE  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_DUTY   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_SPARE  = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_STEP   = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT  = 6'h24;

  // Field positions
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned ST_RUN    = 0;
  localparam int unsigned ST_PIN    = 1;
  localparam int unsigned ST_RANGE  = 2;

  // Reset values
  localparam logic [CNT_W-1:0] CYCLE_RST   = 16'h001D;
  localparam logic [CNT_W-1:0] DUTY_RST    = 16'h000E;
  localparam logic [CNT_W-1:0] SPARE_RST   = 16'h001C;
  localparam logic [CNT_W-1:0] COUNT_START = 16'h0000;
  localparam logic             PIN_HIGH    = 1'b1;
  localparam logic             PIN_LOW     = 1'b0;

  // Timing
  localparam int unsigned CLK_PERIOD_PS  = 25000;
  localparam int unsigned OUT_PERIOD_NS  = 250;
  localparam int unsigned OUT_PERIOD_CYC = (OUT_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic {
    VAR_PAIR = 1'b0,
    VAR_SAW  = 1'b1
  } variant_t;

  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b01,
    RUN_COUNT = 2'b10
  } run_state_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
  } bus_req_t;

endpackage

// ==== core/rcc_period_counter.sv ====
// Up-counting period counter cleared on cycle compare match
`timescale 1ns/1ps
module rcc_period_counter #(
  parameter int unsigned W = rcc_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         run_i,
  input  wire logic [W-1:0] cycle_i,
  // Status
  output logic      [W-1:0] count_o,
  output logic              wrap_o
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  if (W < 2 || W > rcc_pkg::DATA_W) begin : g_bad_width
    $error("period counter width out of range");
  end

  // Overshoot after a live shrink of the cycle still wraps at once
  assign wrap_o  = run_i && (count_q >= cycle_i);
  assign count_d = (!run_i || wrap_o) ? W'(rcc_pkg::COUNT_START) : count_q + 1'b1;
  assign count_o = count_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= W'(rcc_pkg::COUNT_START);
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ==== core/rcc_avalon_slave.sv ====
// Avalon-MM handshake with one wait state and registered read data
`timescale 1ns/1ps
module rcc_avalon_slave (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // Request and read value
  input  wire rcc_pkg::bus_req_t         req_i,
  input  wire logic [rcc_pkg::DATA_W-1:0] rdval_i,
  // Answer
  output logic                           waitrequest_o,
  output logic      [rcc_pkg::DATA_W-1:0] readdata_o,
  output logic                           wr_stb_o
);

  logic                       ack_q;
  logic [rcc_pkg::DATA_W-1:0] rdata_q;
  logic                       pending;

  assign pending       = req_i.rd | req_i.wr;
  assign waitrequest_o = pending & ~ack_q;
  assign wr_stb_o      = req_i.wr & ack_q;
  assign readdata_o    = rdata_q;

  // Read data is sampled one edge early so it stands when waitrequest drops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= pending & ~ack_q;
      if (req_i.rd && !ack_q) begin
        rdata_q <= rdval_i;
      end
    end
  end

endmodule

// ==== bench/rdc_clock_sink.sv ====
// Converter clock input model: measures period and high time of the clock pin
`timescale 1ns/1ps
module resolver_converter_clock_sink (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Converter clock pin
  input  wire logic        pin_i,
  // Measurements in clock cycles
  output logic      [15:0] period_o,
  output logic      [15:0] high_o
);
  logic        pin_q;
  logic [15:0] cnt_q;
  wire         rise = pin_i & ~pin_q;
  wire         fall = ~pin_i & pin_q;

  // Only edges are used, so a stopped pin leaves the last figures standing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_q    <= pin_i;
      cnt_q    <= 16'h0000;
      period_o <= 16'h0000;
      high_o   <= 16'h0000;
    end else begin
      pin_q <= pin_i;
      cnt_q <= rise ? 16'h0001 : cnt_q + 16'h0001;
      if (rise) begin
        period_o <= cnt_q;
      end
      if (fall) begin
        high_o <= cnt_q;
      end
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench: both variants side by side on one register bus
`timescale 1ns/1ps
module tb;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [5:0]  adr     = 6'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdat    = 32'h0000_0000;
  logic [3:0]  ben     = 4'hF;
  logic [31:0] rdat_p;
  logic [31:0] rdat_s;
  logic        wait_p;
  logic        wait_s;
  logic        pin_p;
  logic        pin_s;
  logic [15:0] per_p;
  logic [15:0] per_s;
  logic [15:0] hi_p;
  logic [15:0] hi_s;
  logic [31:0] d0;
  logic        pin_seen_p = 1'b0;
  logic        pin_seen_s = 1'b0;
  logic        stat_last  = 1'b0;
  int          bad_count    = 0;
  int          total_checks = 0;
  int unsigned cyc;
  int unsigned duty;

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  rcc_clock_pwm #(.VARIANT(rcc_pkg::VAR_PAIR)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(ben),
    .avs_readdata_o(rdat_p), .avs_waitrequest_o(wait_p), .clock_out_pin_o(pin_p));
  rcc_clock_pwm #(.VARIANT(rcc_pkg::VAR_SAW)) DUT_SAW (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(ben),
    .avs_readdata_o(rdat_s), .avs_waitrequest_o(wait_s), .clock_out_pin_o(pin_s));
  resolver_converter_clock_sink sink_p (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_i(pin_p), .period_o(per_p),
    .high_o(hi_p));
  resolver_converter_clock_sink sink_s (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_i(pin_s), .period_o(per_s),
    .high_o(hi_s));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One edge of idle first, so a release and a new request never share a step
  task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    logic [31:0] exp_s;
    n = 0;
    @(posedge clk_i);
    adr  <= a;
    rd   <= r;
    wr   <= ~r;
    wdat <= d;
    ben  <= b;
    do begin
      @(negedge clk_i);
      n++;
      // Pin level that the read data captures at the first request edge
      if (n == 1 && r) begin
        pin_seen_p = pin_p;
        pin_seen_s = pin_s;
        stat_last  = (a == rcc_pkg::OFF_STATUS);
      end
    end while (wait_p !== 1'b0 && n < 20);
    if (n >= 20) begin
      bad_count++;
      tally_and_finish();
    end
    chk("saw waitrequest", 32'h0, 32'(wait_s));
    @(posedge clk_i);
    d0 = rdat_p;
    // Status pin bit differs by variant after a stop, so it is taken from the saw pin
    exp_s = rdat_p & ~(32'h1 << rcc_pkg::ST_PIN);
    exp_s = stat_last ? (exp_s | (32'(pin_seen_s) << rcc_pkg::ST_PIN)) : rdat_p;
    chk("saw readdata", exp_s, rdat_s);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0000_0000, 4'hF);
    chk(what, exp, d0);
  endtask

  function automatic logic [31:0] exp_period(input int unsigned c);
    return 32'(c + 1);
  endfunction

  // Settle three periods, then compare both pins against the programmed counts
  task automatic meas(input int unsigned c, input int unsigned du);
    repeat (3 * (c + 1) + 4) @(posedge clk_i);
    chk("pair period", exp_period(c), 32'(per_p));
    chk("pair high", 32'(du + 1), 32'(hi_p));
    chk("saw period", exp_period(c), 32'(per_s));
    chk("saw high", 32'(du + 1), 32'(hi_s));
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(65));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk("pair pin at reset", 32'h1, 32'(pin_p));
    chk("saw pin at reset", 32'h0, 32'(pin_s));
    rd_chk("cycle reset", rcc_pkg::OFF_CYCLE, 32'h0000_001D);
    rd_chk("duty reset", rcc_pkg::OFF_DUTY, 32'h0000_000E);
    for (int i = 0; i < rcc_pkg::SPARE_N; i++) begin
      rd_chk("spare reset", rcc_pkg::OFF_SPARE + 6'(4 * i), 32'h0000_001C);
    end
    rd_chk("unmapped", 6'h3C, 32'h0000_0000);
    $display("test reset done");
    bus(1'b0, rcc_pkg::OFF_CTRL, 32'h0000_0001, 4'hF);
    repeat (2) @(negedge clk_i);
    chk("saw pin at start", 32'h1, 32'(pin_s));
    meas(29, 14);
    $display("test default run done");
    bus(1'b0, rcc_pkg::OFF_DUTY, 32'h0000_0004, 4'hF);
    bus(1'b0, rcc_pkg::OFF_CYCLE, 32'h0000_0009, 4'hF);
    bus(1'b1, rcc_pkg::OFF_COUNT, 32'h0000_0000, 4'hF);
    chk("count after shrink", 32'h1, 32'(d0 <= 32'h9));
    meas(9, 4);
    chk("output period", 32'(rcc_pkg::OUT_PERIOD_CYC), 32'(per_p));
    $display("test direct write done");
    bus(1'b0, rcc_pkg::OFF_SPARE, 32'h0000_001E, 4'hF);
    bus(1'b1, rcc_pkg::OFF_STATUS, 32'h0000_0000, 4'hF);
    chk("range set", 32'h0000_0005 | (32'(pin_seen_p) << rcc_pkg::ST_PIN), d0);
    // Every spare must sit at or below the cycle before the flag can clear
    for (int i = 0; i < rcc_pkg::SPARE_N; i++) begin
      bus(1'b0, rcc_pkg::OFF_SPARE + 6'(4 * i), 32'h0000_0009, 4'hF);
    end
    bus(1'b0, rcc_pkg::OFF_STATUS, 32'h0000_0004, 4'hF);
    bus(1'b1, rcc_pkg::OFF_STATUS, 32'h0000_0000, 4'hF);
    chk("range cleared", 32'h0, 32'(d0[rcc_pkg::ST_RANGE]));
    $display("test range done");
    bus(1'b0, rcc_pkg::OFF_CYCLE, 32'h0000_FF12, 4'h1);
    rd_chk("lane 0 only", rcc_pkg::OFF_CYCLE, 32'h0000_0012);
    meas(18, 4);
    $display("test byte lanes done");
    for (int k = 0; k < 6; k++) begin
      cyc  = 4 + ($urandom % 28);
      duty = $urandom % cyc;
      bus(1'b0, rcc_pkg::OFF_CYCLE, 32'(cyc), 4'hF);
      bus(1'b0, rcc_pkg::OFF_DUTY, 32'(duty), 4'hF);
      meas(cyc, duty);
    end
    $display("test random settings done");
    bus(1'b0, rcc_pkg::OFF_CTRL, 32'h0000_0000, 4'hF);
    repeat (3) @(negedge clk_i);
    chk("saw pin at stop", 32'h0, 32'(pin_s));
    rd_chk("count at stop", rcc_pkg::OFF_COUNT, 32'h0000_0000);
    bus(1'b1, rcc_pkg::OFF_STATUS, 32'h0000_0000, 4'hF);
    chk("run flag at stop", 32'h0, 32'(d0[rcc_pkg::ST_RUN]));
    bus(1'b0, rcc_pkg::OFF_CTRL, 32'h0000_0001, 4'hF);
    repeat (2) @(negedge clk_i);
    chk("saw pin at restart", 32'h1, 32'(pin_s));
    $display("test stop done");
    tally_and_finish();
  end
endmodule
